// [tw_pkg.sv]
package tw_pkg;

   // Register port
   localparam int TW_AW = 2;
   localparam logic [1:0] TW_REG_CONTROL = 2'h0;
   localparam logic [1:0] TW_REG_STATE = 2'h1;
   localparam logic [1:0] TW_REG_BUFFER = 2'h2;
   localparam logic [1:0] TW_REG_OWN_ADDR = 2'h3;

   // Control register fields
   localparam int TW_CTL_FLAG = 7;
   localparam int TW_CTL_ACK_EN = 6;
   localparam int TW_CTL_START = 5;
   localparam int TW_CTL_STOP = 4;
   localparam int TW_CTL_WCOL = 3;
   localparam int TW_CTL_ENABLE = 2;
   localparam int TW_CTL_IRQ_EN = 0;

   // Reset values
   localparam logic [7:0] TW_CONTROL_RST = 8'h00;
   localparam logic [7:0] TW_STATE_RST = 8'hF8;
   localparam logic [7:0] TW_BUFFER_RST = 8'hFF;
   localparam logic [7:0] TW_OWN_ADDR_RST = 8'h00;

   // Status codes, prescaler bits zero
   localparam logic [7:0] TW_CODE_MASK = 8'hF8;
   localparam logic [7:0] TW_ST_START = 8'h08;
   localparam logic [7:0] TW_ST_RSTART = 8'h10;
   localparam logic [7:0] TW_ST_AW_ACK = 8'h18;
   localparam logic [7:0] TW_ST_AW_NACK = 8'h20;
   localparam logic [7:0] TW_ST_DATA_ACK = 8'h28;
   localparam logic [7:0] TW_ST_DATA_NACK = 8'h30;
   localparam logic [7:0] TW_ST_ARB_LOST = 8'h38;
   localparam logic [7:0] TW_ST_AR_ACK = 8'h40;
   localparam logic [7:0] TW_ST_AR_NACK = 8'h48;
   localparam logic [7:0] TW_ST_SLV_WR = 8'h68;
   localparam logic [7:0] TW_ST_SLV_GC = 8'h78;
   localparam logic [7:0] TW_ST_SLV_RD = 8'hB0;

   // Timing: one quarter of a serial bit
   localparam int TW_CLK_NS = 20;
   localparam int TW_QUARTER_NS = 2500;
   localparam int TW_QUARTER_CYCLES = (TW_QUARTER_NS / TW_CLK_NS) < 1 ? 1 : (TW_QUARTER_NS / TW_CLK_NS);

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_WAIT = 8'h02,
      ST_START = 8'h04,
      ST_BYTE = 8'h08,
      ST_STOP = 8'h10,
      ST_HOLD = 8'h20,
      ST_LOST = 8'h40,
      ST_SACK = 8'h80
   } tw_state_t;

endpackage

// [tw_sync.sv]
`timescale 1ns/100ps
module tw_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lines
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta;

   // Pins idle high, so reset to the released level
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta[i] <= 1'b1;
               dout[i] <= 1'b1;
            end else begin
               meta[i] <= din[i];
               dout[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule

// [tw_master_tx.sv]
`timescale 1ns/100ps
module tw_master_tx #(
   parameter int QUARTER_CYCLES = tw_pkg::TW_QUARTER_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [tw_pkg::TW_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial clock line
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   // Serial data line
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);
   import tw_pkg::*;

   logic [1:0] line_s;
   logic scl_s, sda_s, scl_d, sda_d, busy;
   logic [15:0] qcnt;
   logic tick, adv, last;
   logic flag, ack_en, sta, sto, wcol, en, irq_en;
   logic [7:0] status, buffer, own_addr;
   tw_state_t st;
   logic [1:0] ph;
   logic [3:0] bitn;
   logic [7:0] shreg, rxsh;
   logic is_addr, rw, ack_n, owner, pend_start;
   logic wr_ctl, wr_buf, wsta, wsto, next_en, go;
   logic start_fin, byte_fin, stop_fin, arb_hit, arb_data_lost, lost_miss, slave_hit;
   logic scl_rise, scl_fall, match, hw_set, sto_clr;
   logic [7:0] next_code, slave_code;

   tw_sync #(.W(2)) u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din({scl_in, sda_in}),
      .dout(line_s)
   );
   assign scl_s = line_s[1];
   assign sda_s = line_s[0];

   // Bus monitor: START sets busy, STOP clears it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         busy <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         if (scl_s && scl_d && sda_d && !sda_s) begin
            busy <= 1'b1;
         end else if (scl_s && scl_d && !sda_d && sda_s) begin
            busy <= 1'b0;
         end
      end
   end
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;

   // Quarter-bit enable
   always_ff @(posedge ref_clk) begin
      if (!rst_n || qcnt == 16'(QUARTER_CYCLES - 1)) begin
         qcnt <= 16'h0000;
      end else begin
         qcnt <= qcnt + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= (qcnt == 16'(QUARTER_CYCLES - 1));
      end
   end
   // Rising clock waits for the line to be seen high; lets slaves stretch
   assign adv = tick && !(ph == 2'd1 && !scl_s);
   assign last = adv && ph == 2'd3;

   // Register strobes and resume decode
   assign wr_ctl = reg_wr && reg_addr == TW_REG_CONTROL;
   assign wr_buf = reg_wr && reg_addr == TW_REG_BUFFER;
   assign wsta = reg_wdata[TW_CTL_START];
   assign wsto = reg_wdata[TW_CTL_STOP];
   assign next_en = wr_ctl ? reg_wdata[TW_CTL_ENABLE] : en;
   assign go = wr_ctl && reg_wdata[TW_CTL_FLAG] && reg_wdata[TW_CTL_ENABLE]
               && (st == ST_IDLE || (st == ST_HOLD && flag));

   // Engine events
   assign start_fin = st == ST_START && last;
   assign byte_fin = st == ST_BYTE && last && bitn == 4'd8;
   assign stop_fin = st == ST_STOP && last;
   assign arb_hit = st == ST_BYTE && adv && ph == 2'd2 && bitn < 4'd8 && shreg[7] && !sda_s;
   assign arb_data_lost = arb_hit && !is_addr;
   assign match = ack_en && (rxsh[7:1] == own_addr[7:1] || (own_addr[0] && rxsh == 8'h00));
   assign lost_miss = st == ST_LOST && bitn == 4'd8 && !match;
   assign slave_hit = st == ST_SACK && scl_fall && bitn == 4'd1;
   assign slave_code = (own_addr[0] && rxsh == 8'h00) ? TW_ST_SLV_GC : (rxsh[0] ? TW_ST_SLV_RD : TW_ST_SLV_WR);
   assign sto_clr = stop_fin || (go && wsto && !owner);

   always_comb begin
      hw_set = 1'b0;
      next_code = status;
      if (start_fin) begin
         hw_set = 1'b1;
         next_code = owner ? TW_ST_RSTART : TW_ST_START;
      end else if (byte_fin) begin
         hw_set = 1'b1;
         if (is_addr && rw) begin
            next_code = ack_n ? TW_ST_AR_NACK : TW_ST_AR_ACK;
         end else if (is_addr) begin
            next_code = ack_n ? TW_ST_AW_NACK : TW_ST_AW_ACK;
         end else begin
            next_code = ack_n ? TW_ST_DATA_NACK : TW_ST_DATA_ACK;
         end
      end else if (arb_data_lost || lost_miss) begin
         hw_set = 1'b1;
         next_code = TW_ST_ARB_LOST;
      end else if (slave_hit) begin
         hw_set = 1'b1;
         next_code = slave_code;
      end
   end

   // Flag: hardware set wins over the software clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag <= TW_CONTROL_RST[TW_CTL_FLAG];
         status <= TW_STATE_RST;
      end else begin
         if (hw_set) begin
            flag <= 1'b1;
            status <= next_code;
         end else if (wr_ctl && reg_wdata[TW_CTL_FLAG]) begin
            flag <= 1'b0;
         end
      end
   end

   // Software control bits
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_en <= TW_CONTROL_RST[TW_CTL_ACK_EN];
         sta <= TW_CONTROL_RST[TW_CTL_START];
         sto <= TW_CONTROL_RST[TW_CTL_STOP];
         en <= TW_CONTROL_RST[TW_CTL_ENABLE];
         irq_en <= TW_CONTROL_RST[TW_CTL_IRQ_EN];
         own_addr <= TW_OWN_ADDR_RST;
      end else begin
         if (wr_ctl) begin
            ack_en <= reg_wdata[TW_CTL_ACK_EN];
            sta <= wsta;
            en <= reg_wdata[TW_CTL_ENABLE];
            irq_en <= reg_wdata[TW_CTL_IRQ_EN];
         end
         if (sto_clr) begin
            sto <= 1'b0;
         end else if (wr_ctl) begin
            sto <= wsto;
         end
         if (reg_wr && reg_addr == TW_REG_OWN_ADDR) begin
            own_addr <= reg_wdata;
         end
      end
   end

   // Buffer guarded by the flag
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         buffer <= TW_BUFFER_RST;
         wcol <= TW_CONTROL_RST[TW_CTL_WCOL];
      end else if (wr_buf) begin
         if (flag) begin
            buffer <= reg_wdata;
            wcol <= 1'b0;
         end else begin
            wcol <= 1'b1;
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            TW_REG_CONTROL: reg_rdata <= {flag, ack_en, sta, sto, wcol, en, 1'b0, irq_en};
            TW_REG_STATE: reg_rdata <= status & TW_CODE_MASK;
            TW_REG_BUFFER: reg_rdata <= buffer;
            default: reg_rdata <= own_addr;
         endcase
      end
   end

   // Open-drain lines only ever pull low
   always_ff @(posedge ref_clk) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
   end

   // Bus engine; idles in HOLD while the flag is set
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !next_en) begin
         st <= ST_IDLE;
         ph <= 2'd0;
         bitn <= 4'd0;
         shreg <= 8'hFF;
         rxsh <= 8'h00;
         is_addr <= 1'b0;
         rw <= 1'b0;
         ack_n <= 1'b1;
         owner <= 1'b0;
         pend_start <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         case (st)
            ST_IDLE: begin
               if (go && wsta && !wsto) begin
                  st <= ST_WAIT;
               end
            end
            ST_HOLD: begin
               if (go) begin
                  ph <= 2'd0;
                  if (wsto && owner) begin
                     st <= ST_STOP;
                     pend_start <= wsta;
                     sda_oe_n <= 1'b0;
                  end else if (wsta && owner) begin
                     st <= ST_START;
                     sda_oe_n <= 1'b1;
                  end else if (wsta) begin
                     st <= ST_WAIT;
                     scl_oe_n <= 1'b1;
                     sda_oe_n <= 1'b1;
                  end else if (owner && !wsto) begin
                     st <= ST_BYTE;
                     shreg <= buffer;
                     bitn <= 4'd0;
                     is_addr <= status == TW_ST_START || status == TW_ST_RSTART;
                     rw <= buffer[0];
                     sda_oe_n <= buffer[7];
                  end else begin
                     st <= ST_IDLE;
                     owner <= 1'b0;
                     scl_oe_n <= 1'b1;
                     sda_oe_n <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if (!busy) begin
                  st <= ST_START;
                  ph <= 2'd0;
                  sda_oe_n <= 1'b1;
               end
            end
            ST_START: begin
               if (adv) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd0) begin
                     scl_oe_n <= 1'b1;
                  end else if (ph == 2'd1) begin
                     sda_oe_n <= 1'b0;
                  end else if (ph == 2'd2) begin
                     scl_oe_n <= 1'b0;
                  end else begin
                     st <= ST_HOLD;
                     owner <= 1'b1;
                  end
               end
            end
            ST_BYTE: begin
               if (adv) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd0) begin
                     scl_oe_n <= 1'b1;
                  end else if (ph == 2'd2) begin
                     rxsh <= {rxsh[6:0], sda_s};
                     if (bitn == 4'd8) begin
                        ack_n <= sda_s;
                     end
                     if (arb_hit) begin
                        owner <= 1'b0;
                        bitn <= bitn + 4'd1;
                        st <= is_addr ? ST_LOST : ST_HOLD;
                     end else begin
                        scl_oe_n <= 1'b0;
                     end
                  end else if (ph == 2'd3) begin
                     if (bitn == 4'd8) begin
                        st <= ST_HOLD;
                     end else begin
                        bitn <= bitn + 4'd1;
                        shreg <= {shreg[6:0], 1'b1};
                        sda_oe_n <= shreg[6];
                     end
                  end
               end
            end
            ST_STOP: begin
               if (adv) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd0) begin
                     scl_oe_n <= 1'b1;
                  end else if (ph == 2'd1) begin
                     sda_oe_n <= 1'b1;
                  end else if (ph == 2'd3) begin
                     owner <= 1'b0;
                     pend_start <= 1'b0;
                     st <= pend_start ? ST_WAIT : ST_IDLE;
                  end
               end
            end
            ST_LOST: begin
               // Follow the winner's address passively
               if (bitn == 4'd8) begin
                  bitn <= 4'd0;
                  st <= match ? ST_SACK : ST_HOLD;
               end else if (scl_rise) begin
                  rxsh <= {rxsh[6:0], sda_s};
                  bitn <= bitn + 4'd1;
               end
            end
            ST_SACK: begin
               if (scl_fall && bitn == 4'd0) begin
                  sda_oe_n <= 1'b0;
                  bitn <= 4'd1;
               end else if (scl_fall) begin
                  sda_oe_n <= 1'b1;
                  scl_oe_n <= 1'b0;
                  st <= ST_HOLD;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_stop_steps;
      (st == ST_STOP) ##[1:1000] (st == ST_WAIT);
   endsequence
   sequence s_released;
      scl_oe_n && sda_oe_n;
   endsequence

   property p_stall;
      flag && !wr_ctl |=> $stable(st) && $stable(ph);
   endproperty
   a_stall: assert property (p_stall) else $error("engine moved while flag set");
   property p_hold_clock;
      flag && owner && st == ST_HOLD |-> !scl_oe_n;
   endproperty
   a_hold_clock: assert property (p_hold_clock) else $error("clock not held low");
   property p_wcol;
      wr_buf && !flag |=> wcol && $stable(buffer);
   endproperty
   a_wcol: assert property (p_wcol) else $error("collision write not dropped");
   property p_rstart_code;
      start_fin && owner |=> flag && status == TW_ST_RSTART && owner;
   endproperty
   a_rstart_code: assert property (p_rstart_code) else $error("repeated start code wrong");
   property p_start_code;
      start_fin && !owner |=> flag && status == TW_ST_START;
   endproperty
   a_start_code: assert property (p_start_code) else $error("start code wrong");
   property p_addr_ack;
      byte_fin && is_addr && !rw |=> status == ($past(ack_n) ? TW_ST_AW_NACK : TW_ST_AW_ACK);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address code wrong");
   property p_data_ack;
      byte_fin && !is_addr |=> status == ($past(ack_n) ? TW_ST_DATA_NACK : TW_ST_DATA_ACK);
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data code wrong");
   property p_send;
      go && owner && !wsta && !wsto |=> st == ST_BYTE && shreg == $past(buffer) ##1 !flag;
   endproperty
   a_send: assert property (p_send) else $error("byte not sent");
   property p_rstart;
      go && owner && wsta && !wsto |=> st == ST_START && $stable(buffer) && owner;
   endproperty
   a_rstart: assert property (p_rstart) else $error("repeated start wrong");
   property p_stop_clear;
      stop_fin |=> (!sto && !owner) and s_released;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop request not cleared");
   property p_stop_start;
      go && owner && wsta && wsto |=> s_stop_steps;
   endproperty
   a_stop_start: assert property (p_stop_start) else $error("stop then start missing");
   property p_arb;
      arb_data_lost |=> (flag && status == TW_ST_ARB_LOST) and s_released;
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration loss not reported");
   property p_release;
      go && status == TW_ST_ARB_LOST && !wsta && !wsto |=> st == ST_IDLE && s_released;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");

endmodule

// [tw_target.sv]
`timescale 1ns/100ps
module tw_target (
   // Wired bus lines
   input wire logic scl,
   input wire logic sda,
   // Behaviour control
   input wire logic ack_on,
   input wire logic grab,
   // Pull-down and observation
   output logic pull,
   output logic [7:0] last_byte,
   output int stops
);
   int bits = 0;
   int bytes = 0;
   logic ack_slot = 1'b0;
   logic grab_hold = 1'b0;
   logic [7:0] shift = 8'h00;

   initial begin
      last_byte = 8'h00;
      stops = 0;
   end

   // Open drain: only ever pulls low, pull-up does the rest
   assign pull = (ack_slot & ack_on) | grab_hold;

   // START restarts the frame count
   always @(negedge sda) begin
      if (scl) begin
         bits = 0;
         bytes = 0;
      end
   end

   always @(posedge sda) begin
      if (scl) begin
         stops = stops + 1;
      end
   end

   // Bits taken MSB first on the rising clock
   always @(posedge scl) begin
      bits = bits + 1;
      if (bits <= 8) begin
         shift = {shift[6:0], sda};
      end
      if (bits == 8) begin
         last_byte = shift;
      end
   end

   // Acknowledge slot spans the ninth clock
   always @(negedge scl) begin
      ack_slot = (bits == 8);
      if (bits == 9) begin
         bits = 0;
         bytes = bytes + 1;
      end
   end

   // Rival master holding data low from the first data bit; dropping it makes a STOP
   always @(grab) begin
      grab_hold = grab && !scl && bits == 0 && bytes > 0;
   end
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb;
   import tw_pkg::*;
   // Short quarter keeps the run small
   localparam int QC = 4;
   typedef struct packed {logic [7:0] val; logic ack; logic [7:0] code;} tw_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic scl_out;
   logic scl_oe_n;
   logic sda_out;
   logic sda_oe_n;
   logic ack_on = 1'b1;
   logic grab = 1'b0;
   logic pull;
   logic [7:0] last_byte;
   int stops;
   int s0;
   int errors = 0;
   int num_checks = 0;
   logic [7:0] v;
   tw_row_t rows [0:3] = '{{8'h5A, 1'b0, TW_ST_AW_NACK}, {8'h3C, 1'b1, TW_ST_DATA_ACK},
                           {8'hC3, 1'b0, TW_ST_DATA_NACK}, {8'h81, 1'b1, TW_ST_DATA_ACK}};
   wire scl = scl_oe_n | scl_out;
   wire sda = (sda_oe_n | sda_out) & ~pull;

   always #10 ref_clk = ~ref_clk;

   tw_master_tx #(.QUARTER_CYCLES(QC)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
      .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   tw_target TGT (.scl(scl), .sda(sda), .ack_on(ack_on), .grab(grab), .pull(pull),
      .last_byte(last_byte), .stops(stops));

   task automatic wrap_up;
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Gap cycle after a write keeps strobe edges apart
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
      @(posedge ref_clk);
   endtask

   task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask

   task automatic st_chk(input logic [7:0] exp);
      rd(TW_REG_STATE, v);
      chk(v & TW_CODE_MASK, exp);
   endtask

   task automatic wait_bit(input int idx, input logic val);
      int n;
      n = 0;
      rd(TW_REG_CONTROL, v);
      while (v[idx] !== val && n < 400) begin
         rd(TW_REG_CONTROL, v);
         n++;
      end
      if (v[idx] !== val) begin
         errors++;
         $display("BAD %0t control bit wait timed out", $time);
         wrap_up();
      end
   endtask

   task automatic start_to(input logic [7:0] ctl, input logic [7:0] code);
      wr(TW_REG_CONTROL, ctl);
      wait_bit(TW_CTL_FLAG, 1'b1);
      st_chk(code);
   endtask

   task automatic send(input logic [7:0] b, input logic [7:0] code);
      wr(TW_REG_BUFFER, b);
      start_to(8'h84, code);
   endtask

   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // Look away from the edge that launches the outputs
      @(negedge ref_clk);
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
      @(posedge ref_clk);
      rdchk(TW_REG_CONTROL, TW_CONTROL_RST);
      rdchk(TW_REG_STATE, TW_STATE_RST);
      rdchk(TW_REG_OWN_ADDR, TW_OWN_ADDR_RST);
      wr(TW_REG_BUFFER, 8'h77);
      rdchk(TW_REG_BUFFER, TW_BUFFER_RST);
      rdchk(TW_REG_CONTROL, 8'h08);
      start_to(8'hA4, TW_ST_START);
      s0 = stops;
      // Nothing moves until software answers
      repeat (40) @(posedge ref_clk);
      chk({7'h00, scl}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ack_on <= rows[i].ack;
         send(rows[i].val, rows[i].code);
         chk(last_byte, rows[i].val);
      end
      ack_on <= 1'b1;
      start_to(8'hA4, TW_ST_RSTART);
      rdchk(TW_REG_BUFFER, 8'h81);
      send(8'h5B, TW_ST_AR_ACK);
      start_to(8'hA4, TW_ST_RSTART);
      send(8'h5A, TW_ST_AW_ACK);
      chk(8'(stops - s0), 8'h00);
      wr(TW_REG_CONTROL, 8'h94);
      wait_bit(TW_CTL_STOP, 1'b0);
      repeat (20) @(posedge ref_clk);
      chk({6'h00, scl, sda}, 8'h03);
      chk(8'(stops - s0), 8'h01);
      rdchk(TW_REG_CONTROL, 8'h04);
      start_to(8'hA4, TW_ST_START);
      send(8'h5A, TW_ST_AW_ACK);
      s0 = stops;
      start_to(8'hB4, TW_ST_START);
      rd(TW_REG_CONTROL, v);
      chk({7'h00, v[TW_CTL_STOP]}, 8'h00);
      chk(8'(stops - s0), 8'h01);
      // Lost arbitration, then give up or retry once the bus frees
      for (int k = 0; k < 2; k++) begin
         send(8'h5A, TW_ST_AW_ACK);
         grab <= 1'b1;
         send(8'hFF, TW_ST_ARB_LOST);
         chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
         wr(TW_REG_CONTROL, (k == 1) ? 8'hA4 : 8'h84);
         repeat (40) @(posedge ref_clk);
         rd(TW_REG_CONTROL, v);
         chk({7'h00, v[TW_CTL_FLAG]}, 8'h00);
         chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
         grab <= 1'b0;
         if (k == 0) begin
            wr(TW_REG_CONTROL, 8'hA4);
         end
         wait_bit(TW_CTL_FLAG, 1'b1);
         st_chk(TW_ST_START);
      end
      wrap_up();
   end
endmodule
